/* File: adc_seq_pkg.sv */
/*
 * Package for the converter sequencer: register offsets, field positions,
 * reset values, channel codes and step counts.
 * Assumes one instruction cycle per i_clk edge at 40 MHz.
 */
package adc_seq_pkg;
	// Register offsets on the core's peripheral address
	localparam logic [7:0] OFF_REFERENCE_CODE = 8'h02;
	localparam logic [7:0] OFF_CHANNEL_SELECT = 8'h24;
	localparam logic [7:0] OFF_MODE_STATUS    = 8'h25;
	// Mode register field positions
	localparam int BIT_COMPARE = 0;
	localparam int BIT_BUSY    = 1;
	localparam int BIT_MODE    = 2;
	// Reset values
	localparam logic [7:0] RST_REFERENCE_CODE = 8'h00;
	localparam logic [2:0] RST_CHANNEL        = 3'h0;
	// Channel codes
	localparam logic [2:0] CH_UNUSED     = 3'h0;
	localparam logic [2:0] CH_PROHIBITED = 3'h7;
	localparam int         NUM_INPUTS    = 6;
	// Timing in instruction cycles
	localparam int SW_COMPARE_CYCLES = 3;
	localparam int HW_DONE_CYCLES    = 17;
	localparam int HW_BUSY_CYCLES    = 15;
	localparam int HW_STEP_BITS      = 8;
	// Reset kinds; only RST_RETAIN keeps register contents
	typedef enum logic [1:0] {
		RST_NONE     = 2'b00,
		RST_FULL     = 2'b01,
		RST_RETAIN   = 2'b10
	} reset_kind_e;
endpackage

/* File: adc_channel_decode.sv */
/*
 * Channel decoder: turns the 3-bit channel code into a one-hot pin route
 * and, while a pin is selected, forces the other shared pins into input mode.
 * Assumes the channel code is a registered value from the same clock.
 */
`timescale 1ns/1ps
module adc_channel_decode #(
	parameter int N = 6
) (
	input  wire logic [2:0]   i_code,       // Channel code
	output logic      [N-1:0] o_route,      // One-hot pin to comparator
	output logic      [N-1:0] o_force_input // Pins forced to input mode
);
	// Only codes 1..N route a pin; 0 and 7 route none
	wire logic any_selected = (o_route != '0);
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gen_pin
			assign o_route[g]       = (i_code == 3'(g + 1));
			assign o_force_input[g] = any_selected && !o_route[g];
		end
	endgenerate
endmodule // adc_channel_decode

/* File: adc_sar_step.sv */
/*
 * Successive-approximation step: given the trial code and the comparator,
 * keeps or drops the bit under test and sets the next lower one.
 * Assumes the caller holds the bit index.
 */
`timescale 1ns/1ps
module adc_sar_step #(
	parameter int W = 8
) (
	input  wire logic [W-1:0]         i_code,    // Current trial code
	input  wire logic [$clog2(W)-1:0] i_bit,     // Bit under test
	input  wire logic                 i_above,   // Input above compare level
	output logic      [W-1:0]         o_next     // Next trial code
);
	wire logic [W-1:0] test_mask = W'(1) << i_bit;
	wire logic [W-1:0] next_mask = test_mask >> 1;
	// Keep the tested bit only when input is above, then try the next bit
	assign o_next = (i_above ? i_code : (i_code & ~test_mask)) | next_mask;
endmodule // adc_sar_step

/* File: adc_sequencer_control.sv */
/*
 * Control logic of an 8-bit successive-approximation converter: channel
 * select, reference code register, compare flag, hardware sequencer.
 * Assumes the core accesses registers by address with one-cycle strobes,
 * the analog comparator answers on i_comp_above, and each i_clk edge is
 * one instruction cycle.
 */
`timescale 1ns/1ps

module adc_sequencer_control #(
	parameter int W = 8
) (
	input  wire logic         i_clk,          // Instruction clock
	input  wire logic         i_reset,        // Power-on/watchdog-stack reset
	input  wire logic         i_soft_reset,   // CE reset or clock stop
	input  wire logic [7:0]   i_addr,         // Register address
	input  wire logic         i_wr,           // Write strobe
	input  wire logic         i_rd,           // Read strobe
	input  wire logic [W-1:0] i_wdata,        // Write data from transfer buffer
	input  wire logic         i_comp_above,   // Comparator: input above level
	output logic      [W-1:0] o_rdata,        // Read data to transfer buffer
	output logic      [W-1:0] o_tap_code,     // Tap code to R-string
	output logic      [5:0]   o_route,        // One-hot analog pin route
	output logic      [5:0]   o_force_input   // Pins forced to input mode
);
	localparam int CW = $clog2(adc_seq_pkg::HW_DONE_CYCLES + 1);

	logic [W-1:0] reference_code;
	logic [2:0]   channel;
	logic         mode_bit;
	logic         compare_flag;
	logic         busy;
	logic         running;
	logic [CW-1:0] hw_count;
	logic [1:0]   sw_count;
	logic         sw_pending;
	logic [$clog2(W)-1:0] bit_idx;
	logic [W-1:0] sar_next;
	logic [5:0]   route_w;
	logic [5:0]   force_w;

	// Address decode
	wire logic wr_ref  = i_wr && (i_addr == adc_seq_pkg::OFF_REFERENCE_CODE);
	wire logic wr_ch   = i_wr && (i_addr == adc_seq_pkg::OFF_CHANNEL_SELECT);
	wire logic wr_mode = i_wr && (i_addr == adc_seq_pkg::OFF_MODE_STATUS);
	wire logic set_mode   = wr_mode && i_wdata[adc_seq_pkg::BIT_MODE];
	wire logic clear_mode = wr_mode && !i_wdata[adc_seq_pkg::BIT_MODE];
	// Bits are tested in the first W cycles of the 17-cycle window
	wire logic step_now = running && (hw_count < CW'(W));
	wire logic hw_done  = running && (hw_count == CW'(adc_seq_pkg::HW_DONE_CYCLES - 1));

	wire logic [3:0] mode_read = {1'b0, mode_bit, busy, compare_flag};
	wire logic [W-1:0] next_rdata =
		!i_rd ? '0 :
		(i_addr == adc_seq_pkg::OFF_REFERENCE_CODE) ? reference_code :
		(i_addr == adc_seq_pkg::OFF_CHANNEL_SELECT) ? W'({1'b0, channel}) :
		(i_addr == adc_seq_pkg::OFF_MODE_STATUS)    ? W'(mode_read) : '0;

	adc_channel_decode #(.N(adc_seq_pkg::NUM_INPUTS)) u_decode (
		.i_code        (channel),
		.o_route       (route_w),
		.o_force_input (force_w)
	);

	adc_sar_step #(.W(W)) u_step (
		.i_code  (reference_code),
		.i_bit   (bit_idx),
		.i_above (i_comp_above),
		.o_next  (sar_next)
	);

	// Channel select; prohibited code 7 is stored but routes nothing
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			channel <= adc_seq_pkg::RST_CHANNEL;
		end else if (wr_ch) begin
			channel <= i_wdata[2:0];
		end
	end

	// Mode bit; soft reset clears it, channel is kept
	always_ff @(posedge i_clk) begin
		if (i_reset || i_soft_reset) begin
			mode_bit <= 1'b0;
		end else if (wr_mode) begin
			mode_bit <= i_wdata[adc_seq_pkg::BIT_MODE];
		end
	end

	// Hardware sequencer run state and cycle count
	always_ff @(posedge i_clk) begin
		if (i_reset || i_soft_reset) begin
			running  <= 1'b0;
			hw_count <= '0;
			busy     <= 1'b0;
		end else if (set_mode) begin
			running  <= 1'b1;
			hw_count <= '0;
			busy     <= 1'b1;
		end else if (clear_mode) begin
			running  <= 1'b0;
			busy     <= 1'b0;
		end else if (running) begin
			hw_count <= hw_count + CW'(1);
			// Busy drops two cycles before the end so a poll loop lands on time
			if (hw_count == CW'(adc_seq_pkg::HW_BUSY_CYCLES - 1))
				busy <= 1'b0;
			if (hw_done)
				running <= 1'b0;
		end
	end

	// Bit under test, MSB first
	always_ff @(posedge i_clk) begin
		if (i_reset || set_mode) begin
			bit_idx <= ($clog2(W))'(W - 1);
		end else if (step_now && bit_idx != '0) begin
			bit_idx <= bit_idx - 1'b1;
		end
	end

	// Next reference code: software writes, hardware steps. Register and tap pins
	// load the same value, so each step judges the code that is on the pins
	wire logic [W-1:0] first_trial    = W'(1) << (W - 1); // MSB under test first
	wire logic         soft_clear_ref = i_soft_reset && mode_bit; // Zero in hardware mode
	wire logic         sw_write       = wr_ref && !mode_bit; // Refused in hardware mode
	wire logic [W-1:0] next_reference_code =
		i_reset        ? adc_seq_pkg::RST_REFERENCE_CODE :
		soft_clear_ref ? adc_seq_pkg::RST_REFERENCE_CODE :
		i_soft_reset   ? reference_code :
		set_mode       ? first_trial :
		step_now       ? sar_next :
		sw_write       ? i_wdata :
		reference_code;

	always_ff @(posedge i_clk) begin
		reference_code <= next_reference_code;
	end

	// Software compare: result latched three cycles after the write
	always_ff @(posedge i_clk) begin
		if (i_reset || i_soft_reset) begin
			sw_pending <= 1'b0;
			sw_count   <= '0;
		end else if (wr_ref && !mode_bit) begin
			sw_pending <= 1'b1;
			sw_count   <= 2'(adc_seq_pkg::SW_COMPARE_CYCLES - 1);
		end else if (sw_pending) begin
			sw_count <= sw_count - 2'(1);
			if (sw_count == 2'(1))
				sw_pending <= 1'b0;
		end
	end

	// Compare flag; it tracks the comparator once the settle time has passed, and holds while a hardware run is active
	always_ff @(posedge i_clk) begin
		if (i_reset || i_soft_reset) begin
			compare_flag <= 1'b0;
		end else if (!running && !sw_pending) begin
			compare_flag <= i_comp_above;
		end
	end

	// Registered outputs
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_rdata       <= '0;
			o_tap_code    <= '0;
			o_route       <= '0;
			o_force_input <= '0;
		end else begin
			o_rdata       <= next_rdata;
			o_tap_code    <= next_reference_code;
			o_route       <= route_w;
			o_force_input <= force_w;
		end
	end

	// Checks
	// Helper for the checks: how long busy has stood since the last start
	logic [CW-1:0] busy_len;
	always_ff @(posedge i_clk) begin
		if (i_reset || i_soft_reset || set_mode || !busy) begin
			busy_len <= '0;
		end else begin
			busy_len <= busy_len + CW'(1);
		end
	end

	// Busy stands through the bit steps of an undisturbed conversion
	chk_busy_width: assert property (
		@(posedge i_clk) disable iff (i_reset || i_soft_reset)
		set_mode ##1 (!wr_mode && !i_soft_reset) [*8] |-> busy)
		else $error("busy dropped early");
	// Busy falls on its own only at the planned count
	chk_busy_clear: assert property (
		@(posedge i_clk) disable iff (i_reset || i_soft_reset)
		$fell(busy) && !$past(wr_mode) |->
			running && hw_count == CW'(adc_seq_pkg::HW_BUSY_CYCLES))
		else $error("busy cleared at wrong cycle");
	// Counted apart from the sequencer's own counter
	chk_busy_len: assert property (
		@(posedge i_clk) disable iff (i_reset || i_soft_reset)
		$fell(busy) && !$past(wr_mode) |-> busy_len == CW'(adc_seq_pkg::HW_BUSY_CYCLES))
		else $error("busy stood the wrong number of cycles");
	// Busy only ever shows in hardware mode
	chk_busy_mode: assert property (
		@(posedge i_clk) disable iff (i_reset)
		busy |-> mode_bit)
		else $error("busy outside hardware mode");
	// Writing 0 to the mode bit stops a running conversion at once
	chk_abort_stop: assert property (
		@(posedge i_clk) disable iff (i_reset)
		clear_mode |=> !running && !busy)
		else $error("abort did not stop");
	// Writing 1 starts a run with the top bit under test
	chk_start_run: assert property (
		@(posedge i_clk) disable iff (i_reset)
		set_mode && !i_soft_reset |=> running && busy && reference_code == 8'h80)
		else $error("start failed");
	// The run ends at the planned count
	chk_done_time: assert property (
		@(posedge i_clk) disable iff (i_reset)
		hw_done && !wr_mode && !i_soft_reset |=> !running)
		else $error("done late");
	// After the bit steps the result stays put for the core to read
	chk_hold_result: assert property (
		@(posedge i_clk) disable iff (i_reset)
		running && !step_now && !wr_mode && !i_soft_reset |=> $stable(reference_code))
		else $error("result moved after the steps");

	// Checks on pin routing and the tap code
	// At most one pin reaches the comparator
	chk_route_hot: assert property (
		@(posedge i_clk) disable iff (i_reset)
		$onehot0(o_route))
		else $error("more than one pin routed");
	// Unused and prohibited codes route no pin
	chk_route_none: assert property (
		@(posedge i_clk) disable iff (i_reset)
		(channel == adc_seq_pkg::CH_UNUSED || channel == adc_seq_pkg::CH_PROHIBITED) |=>
			o_route == '0)
		else $error("pin routed for unused code");
	// Every other shared pin is held as an input
	chk_force_other: assert property (
		@(posedge i_clk) disable iff (i_reset)
		(o_route != '0) |-> (o_force_input == ~o_route))
		else $error("other pins not forced");
	// The tap pins never lag the code being judged
	chk_tap_follow: assert property (
		@(posedge i_clk) disable iff (i_reset)
		o_tap_code == reference_code)
		else $error("tap code differs from reference");

	// Checks on the software compare path and the register bus
	// The flag is frozen for the settle time of an undisturbed write
	chk_sw_settle: assert property (
		@(posedge i_clk) disable iff (i_reset || i_soft_reset)
		wr_ref && !mode_bit ##1 !wr_ref [*2] |->
			sw_pending && $past(sw_pending) ##1 !sw_pending)
		else $error("software settle wrong");
	// No flag update while the compare level settles
	chk_sw_frozen: assert property (
		@(posedge i_clk) disable iff (i_reset || i_soft_reset)
		sw_pending |=> $stable(compare_flag))
		else $error("flag moved while settling");
	// Once settled the flag shows the comparator
	chk_cmp_track: assert property (
		@(posedge i_clk) disable iff (i_reset)
		!running && !sw_pending && !i_soft_reset |=> compare_flag == $past(i_comp_above))
		else $error("flag does not follow comparator");
	// Read data stands for one cycle only
	chk_rdata_idle: assert property (
		@(posedge i_clk) disable iff (i_reset)
		!i_rd |=> o_rdata == '0)
		else $error("read data without a read");
	// The 4-bit registers read 0 above their fields
	chk_bit3_zero: assert property (
		@(posedge i_clk) disable iff (i_reset)
		i_rd && (i_addr == adc_seq_pkg::OFF_MODE_STATUS ||
			i_addr == adc_seq_pkg::OFF_CHANNEL_SELECT) |=> o_rdata[W-1:3] == '0)
		else $error("bit 3 not zero");
	// A reference write in hardware mode leaves the result alone
	chk_ref_refused: assert property (
		@(posedge i_clk) disable iff (i_reset)
		wr_ref && mode_bit && !running && !i_soft_reset |=> $stable(reference_code))
		else $error("reference written in hardware mode");

	// Coverage of the main scenarios
	cov_hw_conv: cover property (@(posedge i_clk) set_mode ##1 running [*8]);
	cov_sw_cmp: cover property (@(posedge i_clk) wr_ref && !mode_bit ##3 compare_flag);
	cov_abort: cover property (@(posedge i_clk) running && clear_mode);
	cov_soft_keep: cover property (@(posedge i_clk)
		i_soft_reset && !mode_bit && reference_code != '0);
	cov_refused: cover property (@(posedge i_clk) wr_ref && mode_bit && !running);
endmodule // adc_sequencer_control

/* File: adc_analog_model.sv */
/*
 * Analog side: the selected pin's voltage compared with the tap level.
 * Assumes the voltage is given in half steps of the tap code.
 */
`timescale 1ns/1ps
module adc_analog_model (
	input  wire logic [7:0] i_tap_code, // Tap code from the block
	input  wire logic [5:0] i_route,    // One-hot pin route
	input  wire logic [8:0] i_vin_x2,   // Pin voltage, half-step units
	output logic            o_above     // Comparator output
);
	// Pins are sensed with pull-downs off, as software must arrange first
	// Odd half steps keep the input off any tap, so no tie is possible
	assign o_above = (|i_route) && (i_vin_x2 > {i_tap_code, 1'b0});
endmodule // adc_analog_model

/* File: adc_sequencer_control_bench.sv */
/*
 * Self-checking bench for the converter control block.
 * Assumes registered read data one cycle after the read strobe.
 */
`timescale 1ns/1ps
module adc_sequencer_control_bench;
	logic       i_clk, i_reset, i_soft_reset, i_wr, i_rd, above;
	logic [7:0] i_addr, i_wdata, rdata, tap, q;
	logic [8:0] vin_x2;
	logic [5:0] route, force_in, er;
	int         err_total, checks_done;

	adc_sequencer_control uut (.i_clk(i_clk), .i_reset(i_reset),
		.i_soft_reset(i_soft_reset), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
		.i_wdata(i_wdata), .i_comp_above(above), .o_rdata(rdata),
		.o_tap_code(tap), .o_route(route), .o_force_input(force_in));
	adc_analog_model model (.i_tap_code(tap), .i_route(route),
		.i_vin_x2(vin_x2), .o_above(above));

	// Instruction clock, 25 ns
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	// Bus tasks start and end at a falling edge
	task wr(input logic [7:0] a, input logic [7:0] d);
		i_addr = a;
		i_wdata = d;
		i_wr = 1'b1;
		cyc(1);
		i_wr = 1'b0;
	endtask
	task rd(input logic [7:0] a);
		i_addr = a;
		i_rd = 1'b1;
		cyc(1);
		q = rdata;
		i_rd = 1'b0;
		cyc(1);
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task t_reset_values;
		rd(8'h02); chk(q, 8'h00);
		rd(8'h24); chk(q, 8'h00);
		rd(8'h25); chk(q, 8'h00);
		rd(8'h10); chk(q, 8'h00);
	endtask
	// Every channel code, prohibited one included
	task t_channels;
		for (int c = 0; c < 8; c++) begin
			wr(8'h24, 8'(c));
			cyc(2);
			er = (c == 0 || c == 7) ? 6'h00 : 6'(1 << (c - 1));
			chk({2'h0, route}, {2'h0, er});
			chk({2'h0, force_in}, {2'h0, (er != 0) ? ~er : 6'h00});
			rd(8'h24); chk(q, 8'(c));
		end
	endtask
	task t_software;
		vin_x2 = 9'h0C1;
		wr(8'h24, 8'h01);
		cyc(1);
		wr(8'h02, 8'h50);
		cyc(3);
		rd(8'h25); chk(q, 8'h01);
		wr(8'h02, 8'h70);
		rd(8'h25); chk(q, 8'h01);
		cyc(2);
		rd(8'h25); chk(q, 8'h00);
		chk(tap, 8'h70);
		rd(8'h02); chk(q, 8'h70);
	endtask
	task t_hardware;
		vin_x2 = 9'h0B5;
		wr(8'h25, 8'h04);
		rd(8'h25); chk(q & 8'h0E, 8'h06);
		wr(8'h02, 8'h11);
		cyc(8);
		rd(8'h25); chk(q & 8'h0E, 8'h06);
		cyc(2);
		rd(8'h25); chk(q & 8'h0E, 8'h04);
		rd(8'h02); chk(q, 8'h5A);
		wr(8'h02, 8'h11);
		rd(8'h02); chk(q, 8'h5A);
		wr(8'h25, 8'h00);
	endtask
	task t_abort;
		cyc(1);
		wr(8'h25, 8'h04);
		cyc(3);
		wr(8'h25, 8'h00);
		rd(8'h25); chk(q & 8'h0E, 8'h00);
	endtask
	task t_soft_reset;
		wr(8'h24, 8'h03);
		cyc(1);
		wr(8'h02, 8'h33);
		i_soft_reset = 1'b1;
		cyc(1);
		i_soft_reset = 1'b0;
		rd(8'h02); chk(q, 8'h33);
		rd(8'h24); chk(q, 8'h03);
		wr(8'h25, 8'h04);
		cyc(20);
		i_soft_reset = 1'b1;
		cyc(1);
		i_soft_reset = 1'b0;
		rd(8'h02); chk(q, 8'h00);
		rd(8'h25); chk(q & 8'h0E, 8'h00);
	endtask

	// Main sequence, inputs change at falling edges
	initial begin
		{i_reset, i_soft_reset, i_wr, i_rd} = 4'b1000;
		{i_addr, i_wdata, vin_x2} = '0;
		err_total = 0;
		checks_done = 0;
		cyc(20);
		i_reset = 1'b0;
		t_reset_values();
		t_channels();
		t_software();
		t_hardware();
		t_abort();
		t_soft_reset();
		wrap_up();
	end

	// Watchdog, far beyond the roughly 150 cycles the tests need
	initial begin
		#100000;
		err_total++;
		wrap_up();
	end
endmodule // adc_sequencer_control_bench
